// ==== logic/pmd_top.sv ====
// Processor mode control, bank-0 decode and external bus sequencer.
//
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
`include "pmd_defs.svh"
// How it works
// - Strap low starts single-chip; any mode selectable.
// - Mode bits 1:0 at 5E select mode.
// - New mode applies after write strobe ends.
// - Single-chip drives no address or data pins.
// - Single-chip ignores wait bit, never waits.
// - Expansion mode ports carry bus and control.
// - Expansion reaches whole 24-bit, 16M-byte space.
// - Overlapped reads return internal data only.
// - Overlapped writes hit internal and external.
// - Microprocessor mode hides internal ROM externally.
// - Microprocessor mode always drives clock output pin.
// - Internal RAM decoded at 0080 to 027F.
// - Internal ROM decoded at C000 to FFFF.
// - FFD6 to FFFF is the vector table.
// - Wait bit resets to zero, one-wait mode.
// - Width strap selects 8-bit or 16-bit bus.
module pmd_top #(
    parameter int PHI_DIV = `PMD_PHI_DIV
) (
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic MODE_STRAP_PIN_I,
    input wire logic BYTE_PIN_I,
    input wire logic CPU_REQ_I,
    input wire logic CPU_WE_I,
    input wire logic [23:0] CPU_ADDR_I,
    input wire logic [15:0] CPU_WDATA_I,
    output logic CPU_ACK_O,
    output logic [15:0] CPU_RDATA_O,
    output logic INT_SFR_SEL_O,
    output logic INT_RAM_SEL_O,
    output logic INT_ROM_SEL_O,
    output logic INT_VEC_O,
    output logic INT_WE_O,
    output logic [15:0] INT_ADDR_O,
    output logic [15:0] INT_WDATA_O,
    input wire logic [15:0] INT_RDATA_I,
    output logic [23:0] EXT_ADDR_O,
    output logic EXT_ADDR_OE_O,
    output logic [15:0] EXT_DATA_O,
    input wire logic [15:0] EXT_DATA_I,
    output logic EXT_DATA_LO_OE_O,
    output logic EXT_DATA_HI_OE_O,
    output logic EXT_E_N_O,
    output logic EXT_RW_O,
    output logic EXT_CTRL_OE_O,
    output logic CLK_OUT_PORT_PIN_O,
    output logic CLK_OUT_PORT_PIN_OE_O
);
    // Refuse a divider that cannot make a tick.
    if (PHI_DIV < 1 || PHI_DIV > 255) begin : g_chk
        $error("PHI_DIV must lie between 1 and 255.");
    end

    // Sequencer states for one CPU access.
    typedef enum logic [2:0] {ST_IDLE, ST_INT, ST_SETUP, ST_STRB, ST_HOLD, ST_ACK} pmd_state_t;

    // Synchronisers for the pins; stage one is read only by stage two.
    logic strap_s1_q, strap_s2_q;
    logic byte_s1_q, byte_s2_q;
    logic [15:0] ext_s1_q, ext_s2_q;

    // Boot sequencing, mode register and pending update.
    logic [1:0] boot_q, boot_d; // Counts the settling cycles after reset.
    logic strap_lock_q, strap_lock_d; // Strap was high at reset release.
    logic [7:0] mode_reg_q, mode_reg_d; // Operating mode control register.
    logic [7:0] pend_q, pend_d; // Value written, not yet applied.
    logic pend_vld_q, pend_vld_d; // A write awaits the end of its strobe.

    // Tick divider and clock output.
    logic [7:0] div_q, div_d;
    logic tick; // One-cycle enable per bus tick.
    logic phi_q, phi_d; // Bus clock image for the clock output pin.

    // Access sequencer state.
    pmd_state_t st_q, st_d;
    logic [23:0] addr_q, addr_d;
    logic we_q, we_d;
    logic [15:0] wdata_q, wdata_d;
    logic [15:0] rdata_q, rdata_d;
    pmd_pkg::pmd_hit_t hit_q, hit_d; // Internal regions of the latched access.
    logic [2:0] cnt_q, cnt_d; // Strobe-low tick counter.

    // Derived mode information.
    pmd_pkg::pmd_mode_t mode;
    logic ext_mode; // Expansion or microprocessor mode.
    logic boot_done;
    logic int_any; // The decoded address hits internal memory.
    logic [2:0] e_len; // Strobe-low length in ticks.

    // APB decode.
    logic apb_wr, apb_rd_mode, apb_rd_stat;

    pmd_dec_if dif();

    pmd_decode u_dec (
        .dbus(dif.dec)
    );

    // Pin synchronisers.
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            strap_s1_q <= 1'b0;
            strap_s2_q <= 1'b0;
            byte_s1_q <= 1'b0;
            byte_s2_q <= 1'b0;
            ext_s1_q <= 16'h0000;
            ext_s2_q <= 16'h0000;
        end else begin
            strap_s1_q <= MODE_STRAP_PIN_I;
            strap_s2_q <= strap_s1_q;
            byte_s1_q <= BYTE_PIN_I;
            byte_s2_q <= byte_s1_q;
            ext_s1_q <= EXT_DATA_I;
            ext_s2_q <= ext_s1_q;
        end
    end

    // Active mode is single-chip until the strap has been caught.
    assign mode = mode_reg_q[1:0];
    assign ext_mode = (mode == `PMD_MODE_EXPAND) || (mode == `PMD_MODE_MICRO);
    assign boot_done = (boot_q == 2'h3);
    assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I && (PADDR_I == `PMD_ADDR_MODE);
    assign apb_rd_mode = (PADDR_I == `PMD_ADDR_MODE);
    assign apb_rd_stat = (PADDR_I == `PMD_ADDR_STAT);

    // Next values of the boot counter and the mode register.
    always_comb begin
        boot_d = boot_q;
        strap_lock_d = strap_lock_q;
        mode_reg_d = mode_reg_q;
        pend_d = pend_q;
        pend_vld_d = 1'b0;
        if (!boot_done) begin
            boot_d = boot_q + 2'h1;
            if (boot_q == 2'h2) begin
                // The synchronised strap is caught once, after the release.
                strap_lock_d = strap_s2_q;
                if (strap_s2_q) begin
                    mode_reg_d[1:0] = `PMD_MODE_MICRO;
                end else begin
                    mode_reg_d[1:0] = `PMD_MODE_SINGLE;
                end
            end
        end
        if (apb_wr && boot_done) begin
            // The write is held until its access strobe has ended.
            pend_d = PWDATA_I[7:0];
            pend_vld_d = 1'b1;
        end
        if (pend_vld_q) begin
            mode_reg_d[7:2] = pend_q[7:2];
            // Reserved code and a strap-locked part keep the old mode.
            if (!strap_lock_q && pend_q[1:0] != `PMD_MODE_RSVD) begin
                mode_reg_d[1:0] = pend_q[1:0];
            end
        end
    end

    // Registers of the boot and mode group.
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            boot_q <= 2'h0;
            strap_lock_q <= 1'b0;
            mode_reg_q <= `PMD_MODE_RESET;
            pend_q <= 8'h00;
            pend_vld_q <= 1'b0;
        end else begin
            boot_q <= boot_d;
            strap_lock_q <= strap_lock_d;
            mode_reg_q <= mode_reg_d;
            pend_q <= pend_d;
            pend_vld_q <= pend_vld_d;
        end
    end

    // APB answers at once; unmapped addresses report an error.
    always_comb begin
        PREADY_O = 1'b1;
        PSLVERR_O = PSEL_I && PENABLE_I && !apb_rd_mode && !apb_rd_stat;
        PRDATA_O = 32'h00000000;
        if (PSEL_I && !PWRITE_I && apb_rd_mode) begin
            PRDATA_O = {24'h000000, mode_reg_q};
        end else if (PSEL_I && !PWRITE_I && apb_rd_stat) begin
            PRDATA_O = {27'h0000000, boot_done, byte_s2_q, strap_lock_q, mode};
        end
    end

    // Tick divider and bus clock image.
    assign tick = (div_q == 8'(PHI_DIV - 1));
    always_comb begin
        div_d = tick ? 8'h00 : div_q + 8'h01;
        phi_d = tick ? !phi_q : phi_q;
    end

    // Registers of the divider group.
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            div_q <= 8'h00;
            phi_q <= 1'b0;
        end else begin
            div_q <= div_d;
            phi_q <= phi_d;
        end
    end

    // The decoder sees the live request while idle, else the latched one.
    assign dif.addr = (st_q == ST_IDLE) ? CPU_ADDR_I : addr_q;
    assign dif.mode = mode;
    assign int_any = dif.hit.sfr || dif.hit.ram || dif.hit.rom;
    // Wait bit clear stretches the strobe; internal cycles never look at it.
    assign e_len = mode_reg_q[`PMD_BIT_WAIT] ? 3'(`PMD_E_LOW_NOWAIT) : 3'(`PMD_E_LOW_WAIT);

    // Next values of the access sequencer.
    always_comb begin
        st_d = st_q;
        addr_d = addr_q;
        we_d = we_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        hit_d = hit_q;
        cnt_d = cnt_q;
        case (st_q)
            ST_IDLE: begin
                if (CPU_REQ_I && boot_done) begin
                    addr_d = CPU_ADDR_I;
                    we_d = CPU_WE_I;
                    wdata_d = CPU_WDATA_I;
                    hit_d = dif.hit;
                    if (int_any) begin
                        st_d = ST_INT;
                    end else if (ext_mode) begin
                        st_d = ST_SETUP;
                    end else begin
                        // Single-chip: nothing leaves the chip, reads give zero.
                        rdata_d = 16'h0000;
                        st_d = ST_ACK;
                    end
                end
            end
            ST_INT: begin
                // Internal data is what the CPU gets, whatever the bus holds.
                rdata_d = INT_RDATA_I;
                st_d = (we_q && ext_mode) ? ST_SETUP : ST_ACK;
            end
            ST_SETUP: begin
                cnt_d = 3'h0;
                if (tick) begin
                    st_d = ST_STRB;
                end
            end
            ST_STRB: begin
                if (tick) begin
                    cnt_d = cnt_q + 3'h1;
                    if (cnt_q == e_len - 3'h1) begin
                        st_d = ST_HOLD;
                    end
                end
            end
            ST_HOLD: begin
                if (tick) begin
                    // An 8-bit bus brings only the low byte on its data port.
                    if (!we_q && !(hit_q.sfr || hit_q.ram || hit_q.rom)) begin
                        rdata_d = byte_s2_q ? {8'h00, ext_s2_q[7:0]} : ext_s2_q;
                    end
                    st_d = ST_ACK;
                end
            end
            ST_ACK: begin
                st_d = ST_IDLE;
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    // Registers of the sequencer group.
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            st_q <= ST_IDLE;
            addr_q <= 24'h000000;
            we_q <= 1'b0;
            wdata_q <= 16'h0000;
            rdata_q <= 16'h0000;
            hit_q <= '0;
            cnt_q <= 3'h0;
        end else begin
            st_q <= st_d;
            addr_q <= addr_d;
            we_q <= we_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            hit_q <= hit_d;
            cnt_q <= cnt_d;
        end
    end

    // CPU and internal memory side.
    assign CPU_ACK_O = (st_q == ST_ACK);
    assign CPU_RDATA_O = rdata_q;
    assign INT_SFR_SEL_O = (st_q == ST_INT) && hit_q.sfr;
    assign INT_RAM_SEL_O = (st_q == ST_INT) && hit_q.ram;
    assign INT_ROM_SEL_O = (st_q == ST_INT) && hit_q.rom;
    assign INT_VEC_O = (st_q == ST_INT) && hit_q.vec;
    assign INT_WE_O = (st_q == ST_INT) && we_q;
    assign INT_ADDR_O = addr_q[15:0];
    assign INT_WDATA_O = wdata_q;

    // Bus pins are driven only outside single-chip mode.
    assign EXT_ADDR_O = addr_q;
    assign EXT_ADDR_OE_O = ext_mode;
    assign EXT_CTRL_OE_O = ext_mode;
    assign EXT_DATA_O = wdata_q;
    assign EXT_DATA_LO_OE_O = ext_mode && we_q && (st_q == ST_STRB || st_q == ST_HOLD);
    assign EXT_DATA_HI_OE_O = EXT_DATA_LO_OE_O && !byte_s2_q;
    assign EXT_E_N_O = !(st_q == ST_STRB);
    assign EXT_RW_O = !(we_q && (st_q == ST_SETUP || st_q == ST_STRB || st_q == ST_HOLD));

    // Clock output: forced in microprocessor mode, selectable in expansion.
    assign CLK_OUT_PORT_PIN_O = phi_q;
    assign CLK_OUT_PORT_PIN_OE_O = (mode == `PMD_MODE_MICRO) ||
        ((mode == `PMD_MODE_EXPAND) && mode_reg_q[`PMD_BIT_CLKSEL]);
endmodule

// ==== logic/pmd_defs.svh ====
// Constants for the processor mode and bank-0 address decode block.
`ifndef PMD_DEFS_SVH
`define PMD_DEFS_SVH

// Register indices and the byte addresses derived from them.
`define PMD_IDX_MODE 12'h05E
`define PMD_IDX_STAT 12'h05F
`define PMD_ADDR_MODE 12'h178
`define PMD_ADDR_STAT 12'h17C

// Fields of the operating mode control register.
`define PMD_BIT_WAIT 2
`define PMD_BIT_CLKSEL 7
`define PMD_MODE_RESET 8'h00

// Mode bit encodings.
`define PMD_MODE_SINGLE 2'h0
`define PMD_MODE_EXPAND 2'h1
`define PMD_MODE_MICRO 2'h2
`define PMD_MODE_RSVD 2'h3

// Bank-0 map.
`define PMD_SFR_LO 16'h0000
`define PMD_SFR_HI 16'h007F
`define PMD_RAM_LO 16'h0080
`define PMD_RAM_HI 16'h027F
`define PMD_ROM_LO 16'hC000
`define PMD_ROM_HI 16'hFFFF
`define PMD_VEC_LO 16'hFFD6

// Bus timing in bus ticks; one tick is PHI_DIV clock cycles.
`define PMD_PHI_DIV 2
`define PMD_E_LOW_NOWAIT 2
`define PMD_E_LOW_WAIT 4

`endif

// ==== logic/pmd_pkg.sv ====
// Types shared by the processor mode and address decode files.
package pmd_pkg;
    // Two mode bits as held in the operating mode control register.
    typedef logic [1:0] pmd_mode_t;
    // Decode result for one bank-0 address.
    typedef struct packed {
        logic sfr;
        logic ram;
        logic rom;
        logic vec;
    } pmd_hit_t;
endpackage

// ==== logic/pmd_dec_if.sv ====
// Interface between the access sequencer and the bank-0 decoder.
`timescale 1ns/100ps
interface pmd_dec_if;
    logic [23:0] addr; // Full 24-bit CPU address.
    pmd_pkg::pmd_mode_t mode; // Active operating mode.
    pmd_pkg::pmd_hit_t hit; // Internal regions that the address hits.
    modport dec (input addr, input mode, output hit);
    modport use_side (output addr, output mode, input hit);
endinterface

// ==== logic/pmd_decode.sv ====
// Bank-0 internal memory decoder for the processor mode block.
`timescale 1ns/100ps
`include "pmd_defs.svh"
module pmd_decode (
    pmd_dec_if.dec dbus
);
    // Returns true when a 16-bit offset lies inside an inclusive range.
    function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    logic bank0; // The address lies in bank 0.
    logic rom_ok; // Internal ROM is visible in the current mode.

    // Pure combinational decode of the internal regions.
    always_comb begin
        bank0 = (dbus.addr[23:16] == 8'h00);
        rom_ok = (dbus.mode != `PMD_MODE_MICRO);
        dbus.hit.sfr = bank0 && in_rng(dbus.addr[15:0], `PMD_SFR_LO, `PMD_SFR_HI);
        dbus.hit.ram = bank0 && in_rng(dbus.addr[15:0], `PMD_RAM_LO, `PMD_RAM_HI);
        dbus.hit.rom = bank0 && rom_ok && in_rng(dbus.addr[15:0], `PMD_ROM_LO, `PMD_ROM_HI);
        dbus.hit.vec = bank0 && in_rng(dbus.addr[15:0], `PMD_VEC_LO, `PMD_ROM_HI);
    end
endmodule

// ==== testbench/pmd_ext_mem.sv ====
// Behavioural external memory on the expansion bus.
`timescale 1ns/100ps
module pmd_ext_mem (
    input wire logic clk_i,
    input wire logic [23:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic e_n_i,
    input wire logic rw_i,
    output logic [15:0] rdata_o,
    output logic [23:0] wr_addr_o,
    output logic [15:0] wr_data_o
);
    int hold_q; // Cycles left that read data stays valid.
    logic e_n_q; // Strobe of the previous cycle.
    initial begin
        rdata_o = 16'h0000;
        hold_q = 0;
        e_n_q = 1'b1;
    end
    // Answers reads at any address, vector area included, and stores writes at strobe end.
    always @(posedge clk_i) begin
        e_n_q <= e_n_i;
        if (!e_n_i && rw_i) begin
            hold_q <= 12;
            rdata_o <= addr_i[15:0] ^ 16'h5A3C;
        end else if (hold_q != 0) begin
            hold_q <= hold_q - 1;
        end else begin
            rdata_o <= ~rdata_o; // Released lines toggle every cycle and never hold stale data steady.
        end
        if (e_n_i && !e_n_q && !rw_i) begin
            wr_addr_o <= addr_i;
            wr_data_o <= wdata_i;
        end
    end
endmodule

// ==== testbench/pmd_top_chk.sv ====
// Port checker for the processor mode block, bound to its top.
`timescale 1ns/100ps
module pmd_top_chk #(
    parameter int PHI_DIV = 2
) (
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic EXT_ADDR_OE_O,
    input wire logic EXT_CTRL_OE_O,
    input wire logic EXT_DATA_LO_OE_O,
    input wire logic EXT_DATA_HI_OE_O,
    input wire logic EXT_E_N_O,
    input wire logic EXT_RW_O,
    input wire logic CPU_ACK_O,
    input wire logic [15:0] CPU_RDATA_O,
    input wire logic [15:0] INT_RDATA_I,
    input wire logic INT_RAM_SEL_O,
    input wire logic INT_ROM_SEL_O,
    input wire logic INT_VEC_O,
    input wire logic INT_WE_O,
    input wire logic [15:0] INT_ADDR_O,
    input wire logic CLK_OUT_PORT_PIN_O,
    input wire logic CLK_OUT_PORT_PIN_OE_O
);
    // One clock domain; strobe counts below assume PHI_DIV of 2.
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RST_I);
    a_single_quiet: assert property (!EXT_ADDR_OE_O |-> EXT_E_N_O && !EXT_DATA_LO_OE_O)
        else $error("bus cycle while pins are ports");
    a_ctrl_follow: assert property (EXT_CTRL_OE_O == EXT_ADDR_OE_O)
        else $error("control pins disagree with address pins");
    a_hi_lane: assert property (EXT_DATA_HI_OE_O |-> EXT_DATA_LO_OE_O)
        else $error("high lane driven alone");
    a_write_dir: assert property (EXT_DATA_LO_OE_O |-> !EXT_RW_O && EXT_ADDR_OE_O)
        else $error("data driven outside a write");
    a_int_read: assert property ((INT_RAM_SEL_O || INT_ROM_SEL_O) && !INT_WE_O
        |=> CPU_ACK_O && CPU_RDATA_O == $past(INT_RDATA_I))
        else $error("internal read data not returned");
    a_ram_map: assert property (INT_RAM_SEL_O |-> INT_ADDR_O >= 16'h0080 && INT_ADDR_O <= 16'h027F)
        else $error("ram select outside its range");
    a_rom_map: assert property (INT_ROM_SEL_O |-> INT_ADDR_O >= 16'hC000)
        else $error("rom select outside its range");
    a_vec_map: assert property (INT_VEC_O |-> INT_ADDR_O >= 16'hFFD6)
        else $error("vector flag outside its range");
    a_strobe_len: assert property ($fell(EXT_E_N_O)
        |-> (!EXT_E_N_O)[*4] ##1 (EXT_E_N_O or (!EXT_E_N_O)[*4] ##1 EXT_E_N_O))
        else $error("strobe width wrong");
    a_clk_period: assert property (CLK_OUT_PORT_PIN_OE_O && $changed(CLK_OUT_PORT_PIN_O)
        |=> $stable(CLK_OUT_PORT_PIN_O) ##1 $changed(CLK_OUT_PORT_PIN_O))
        else $error("clock output period wrong");
    c_ext_read: cover property ($rose(EXT_E_N_O) && EXT_RW_O);
    c_int_read: cover property (INT_RAM_SEL_O && !INT_WE_O);
    c_clk_out: cover property (CLK_OUT_PORT_PIN_OE_O);
endmodule
bind pmd_top pmd_top_chk #(.PHI_DIV(PHI_DIV)) u_chk (
    .MCLK_I(MCLK_I), .RST_I(RST_I), .EXT_ADDR_OE_O(EXT_ADDR_OE_O), .EXT_CTRL_OE_O(EXT_CTRL_OE_O),
    .EXT_DATA_LO_OE_O(EXT_DATA_LO_OE_O), .EXT_DATA_HI_OE_O(EXT_DATA_HI_OE_O), .EXT_E_N_O(EXT_E_N_O),
    .EXT_RW_O(EXT_RW_O), .CPU_ACK_O(CPU_ACK_O), .CPU_RDATA_O(CPU_RDATA_O), .INT_RDATA_I(INT_RDATA_I),
    .INT_RAM_SEL_O(INT_RAM_SEL_O), .INT_ROM_SEL_O(INT_ROM_SEL_O), .INT_VEC_O(INT_VEC_O),
    .INT_WE_O(INT_WE_O), .INT_ADDR_O(INT_ADDR_O), .CLK_OUT_PORT_PIN_O(CLK_OUT_PORT_PIN_O),
    .CLK_OUT_PORT_PIN_OE_O(CLK_OUT_PORT_PIN_OE_O));

// ==== testbench/pmd_top_tb_top.sv ====
// Testbench for the processor mode and bank-0 decode block.
`timescale 1ns/100ps
module pmd_top_tb_top;
    localparam logic [11:0] MREG = 12'h178; // Mode register byte address.
    localparam logic [11:0] SREG = 12'h17C; // Status register byte address.
    logic clk, rst, psel, pen, pwr, strap, byte_pin, req, we, ack, err, pready, pslverr;
    logic aoe, e_n, rw, coe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [23:0] caddr, eaddr, waddr;
    logic [15:0] cwdata, crd, int_addr, int_rd, edo, edi, wdat;
    int errors, cmp_count;
    wire [3:0] sels; // Internal selects: SFR, RAM, ROM, vector.
    logic [3:0] sel; // Selects seen during the last CPU access.
    logic int_we;
    logic [15:0] int_wd, iwd; // Internal write data and its last captured value.
    int lat; // Edges from the take edge to the acknowledge edge.
    // Internal memory answers with a pattern of its address.
    assign int_rd = int_addr ^ 16'h0F0F;
    pmd_top #(.PHI_DIV(2)) dut (
        .MCLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .MODE_STRAP_PIN_I(strap), .BYTE_PIN_I(byte_pin), .CPU_REQ_I(req), .CPU_WE_I(we),
        .CPU_ADDR_I(caddr), .CPU_WDATA_I(cwdata), .CPU_ACK_O(ack), .CPU_RDATA_O(crd),
        .INT_SFR_SEL_O(sels[3]), .INT_RAM_SEL_O(sels[2]), .INT_ROM_SEL_O(sels[1]), .INT_VEC_O(sels[0]),
        .INT_WE_O(int_we), .INT_ADDR_O(int_addr), .INT_WDATA_O(int_wd), .INT_RDATA_I(int_rd), .EXT_ADDR_O(eaddr),
        .EXT_ADDR_OE_O(aoe), .EXT_DATA_O(edo), .EXT_DATA_I(edi), .EXT_DATA_LO_OE_O(),
        .EXT_DATA_HI_OE_O(), .EXT_E_N_O(e_n), .EXT_RW_O(rw), .EXT_CTRL_OE_O(),
        .CLK_OUT_PORT_PIN_O(), .CLK_OUT_PORT_PIN_OE_O(coe));
    pmd_ext_mem mem (.clk_i(clk), .addr_i(eaddr), .wdata_i(edo), .e_n_i(e_n), .rw_i(rw),
        .rdata_o(edi), .wr_addr_o(waddr), .wr_data_o(wdat));
    // Compares one value and counts the result.
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // One register transfer; read data and error are taken at the ready edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // One CPU access; the request stands until the edge at which the acknowledge is seen.
    // Internal selects and write data are gathered on the way, and the latency is counted.
    task automatic cpu(input logic w, input logic [23:0] a, input logic [15:0] d);
        @(posedge clk);
        req <= 1'b1;
        we <= w;
        caddr <= a;
        cwdata <= d;
        lat = -1;
        sel = 4'h0;
        do begin
            @(posedge clk);
            lat++;
            sel = sel | sels;
            if (int_we) iwd = int_wd;
        end while (ack !== 1'b1);
        req <= 1'b0;
    endtask
    // Prints the verdict and ends the run.
    task automatic report_and_stop;
        if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Cuts a hang short well beyond the expected run length.
    initial begin
        #200000;
        errors++;
        report_and_stop;
    end
    // Main sequence of scenarios.
    initial begin
        {rst, psel, pen, pwr, strap, byte_pin, req, we} = 8'h80;
        paddr = 12'h000;
        pwdata = 32'h0;
        caddr = 24'h0;
        cwdata = 16'h0;
        errors = 0;
        cmp_count = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        apb(0, MREG, 0); chk("mode_reset", 32'h0, rd);
        apb(0, SREG, 0); chk("start_mode", 32'h0, rd[1:0]);
        apb(0, 12'h100, 0); chk("unmapped_err", 32'h1, err);
        chk("single_oe", 32'h0, aoe);
        cpu(0, 24'h000100, 0); chk("ram_rd", 16'h0100 ^ 16'h0F0F, crd);
        chk("ram_sel", 32'h4, sel);
        chk("int_lat", 32'h2, lat);
        cpu(0, 24'h00FFE0, 0); chk("vec_rd", 16'hFFE0 ^ 16'h0F0F, crd);
        chk("rom_sel", 32'h3, sel);
        cpu(0, 24'h00005E, 0); chk("sfr_rd", 16'h005E ^ 16'h0F0F, crd);
        chk("sfr_sel", 32'h8, sel);
        cpu(0, 24'h010000, 0); chk("bank1_rd", 32'h0, crd);
        cpu(0, 24'h001000, 0); chk("miss_rd", 32'h0, crd);
        chk("miss_lat", 32'h1, lat);
        apb(1, MREG, 32'h01); #1 chk("oe_early", 32'h0, aoe);
        @(posedge clk); #1 chk("oe_late", 32'h1, aoe);
        cpu(0, 24'h123456, 0); chk("ext_rd", 16'h3456 ^ 16'h5A3C, crd);
        cpu(0, 24'h000100, 0); chk("ovl_rd", 16'h0100 ^ 16'h0F0F, crd);
        cpu(1, 24'h000120, 16'hBEEF); chk("ovl_wa", 32'h120, waddr);
        chk("ovl_wd", 32'hBEEF, wdat);
        chk("ovl_iwd", 32'hBEEF, iwd);
        chk("clk_oe_exp", 32'h0, coe);
        apb(1, MREG, 32'h85); cpu(0, 24'h020002, 0); chk("nowait_rd", 16'h0002 ^ 16'h5A3C, crd);
        chk("clk_oe_sel", 32'h1, coe);
        @(posedge clk) byte_pin <= 1'b1;
        repeat (4) @(posedge clk);
        cpu(0, 24'h020010, 0); chk("byte_rd", (16'h0010 ^ 16'h5A3C) & 16'h00FF, crd);
        @(posedge clk) byte_pin <= 1'b0;
        apb(1, MREG, 32'h02);
        cpu(0, 24'h00FFE0, 0); chk("ext_vec", 16'hFFE0 ^ 16'h5A3C, crd);
        chk("clk_oe_mp", 32'h1, coe);
        chk("mp_no_rom", 32'h0, sel);
        apb(1, MREG, 32'h03); apb(0, SREG, 0); chk("rsvd_mode", 32'h2, rd[1:0]);
        apb(1, MREG, 32'h00); @(posedge clk); #1 chk("back_single", 32'h0, aoe);
        @(posedge clk);
        strap <= 1'b1;
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        apb(0, SREG, 0); chk("strap_mode", 32'h2, rd[1:0]);
        apb(1, MREG, 32'h00); apb(0, SREG, 0); chk("mode_lock", 32'h2, rd[1:0]);
        report_and_stop;
    end
endmodule
